// >>> design/amc_cal.v
`timescale 1ns/100ps
`include "amc_regs.vh"

// ********************************************************
// Offset and gain correction stage
// ********************************************************
module amc_cal
(
  input  wire        clk,
  input  wire        rst,
  input  wire        in_valid,
  input  wire [23:0] in_data,
  input  wire [23:0] offset_word,
  input  wire [23:0] gain_word,
  output reg         out_valid,
  output reg  [23:0] out_data,
  output reg         out_ovr
);

  wire signed [24:0] diff;
  wire signed [49:0] prod;
  wire signed [27:0] scaled;

  // Offset removed first, then scaled; unity gain is 400000h
  assign diff   = $signed({in_data[23], in_data}) -
                  $signed({offset_word[23], offset_word});
  assign prod   = diff * $signed({1'b0, gain_word});
  assign scaled = prod[`AMC_GAIN_SHIFT+27:`AMC_GAIN_SHIFT];

  // Clip to 24 bits and flag anything beyond 106 percent of range
  always @(posedge clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data  <= 24'h000000;
      out_ovr   <= 1'b0;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
      begin
        if (scaled > $signed(28'h07FFFFF))
          out_data <= 24'h7FFFFF;
        else if (scaled < $signed(28'hF800000))
          out_data <= 24'h800000;
        else
          out_data <= scaled[23:0];
        out_ovr <= (scaled > $signed(`AMC_OVR_LIMIT)) ||
                   (scaled < -$signed(`AMC_OVR_LIMIT));
      end
    end
  end

endmodule // amc_cal

// >>> design/amc_ctl.v
// How it works
// - In ac mode one conversion runs normal polarity, the next reversed.
// - Reversed conversions invert the reference; normal minus reversed.
// - Excitation phases never overlap; a gap separates every change.
// - Excitation toggles only once per finished conversion.
// - Polarity field 10 drives phase a on pin 0, phase b on 1.
// - Polarity field 11 drives phase a on pins 0,2 and b on 1,3.
// - Use external clock when present, else internal; report source.
// - Power-down pin low disables all functions; registers are kept.
// - Power-down bit stops functions but keeps register access alive.
// - Excitation pins are released (EXCITE_GPIO_OE_N high) during either power-down.
// - Power-on resets all logic; reset pin and command reset registers, flags, state.
// - Any reset sets a sticky flag that only the host clears.
// - After power-on, data ready low for 2^16 master clocks, then high.
// - With start high after reset, conversions begin 512 clocks later.
// - Output is (filter minus offset) times gain over 400000h, clipped.
// - Offset word is 24-bit signed in bytes 07h, 08h, 09h.
// - Gain word is 24-bit unsigned, unity 400000h, bytes 0Ah-0Ch.
// - Calibrated signal beyond 106 percent of range is overrange.
// - Alternating modes drop the first result; output is half difference.
// - Alternating modes double the first-conversion latency.
`timescale 1ns/100ps
`include "amc_regs.vh"

module amc_ctl
#(
  parameter POR_TICKS   = `AMC_POR_TICKS,
  parameter START_TICKS = `AMC_START_TICKS,
  parameter GAP_TICKS   = `AMC_GAP_TICKS
)
(
  input  wire        CLK,
  input  wire        SYS_RST,
  input  wire        EXT_CLOCK_INPUT,
  input  wire        RESET_PIN_N,
  input  wire        POWER_DOWN_CTL_N,
  input  wire        START,
  input  wire        CMD_RESET,
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [7:0]  REG_ADDR,
  input  wire [7:0]  REG_WDATA,
  output reg  [7:0]  REG_RDATA,
  input  wire        FILTER_VALID,
  input  wire [23:0] FILTER_DATA,
  input  wire        DATA_ACK,
  output wire        DATA_VALID,
  output wire [23:0] DATA_OUT,
  output wire        OVERRANGE,
  output reg         DATA_READY_OUT,
  output reg         CONV_RUN,
  output reg         REF_INVERT,
  output reg         FUNC_ENABLE,
  output reg         MASTER_TICK,
  output wire [3:0]  EXCITE_GPIO,
  output wire        EXCITE_GPIO_OE_N
);

  // ********************************************************
  // States
  // ********************************************************
  localparam ST_POR   = 2'b00;
  localparam ST_IDLE  = 2'b01;
  localparam ST_DELAY = 2'b10;
  localparam ST_RUN   = 2'b11;

  localparam [63:0] NCO_FULL =
    ((`AMC_FCLK_HZ << `AMC_NCO_BITS) / `AMC_SYS_HZ);
  localparam [23:0] NCO_STEP = NCO_FULL[23:0];

  reg  [1:0]  ext_s;
  reg  [1:0]  rstn_s;
  reg  [1:0]  pdn_s;
  reg  [1:0]  start_s;
  reg         ext_q;
  reg  [7:0]  ext_gap;
  reg         ext_present;
  reg  [23:0] nco;
  reg  [1:0]  state;
  reg  [16:0] cnt;
  reg  [1:0]  pol_mode;
  reg         sw_pdown;
  reg  [23:0] offset_word;
  reg  [23:0] gain_word;
  reg         reset_flag;
  reg         ovr_flag;
  reg         phase;
  reg         have_prev;
  reg  [23:0] prev_data;
  reg         comb_valid;
  reg  [23:0] comb_data;

  wire        ext_rise;
  wire [24:0] nco_sum;
  wire        soft_rst;
  wire        hw_pd;
  wire        pd;
  wire        ac_mode;
  wire        running;
  wire        conv_done;
  wire        stat_clr;
  wire [24:0] half_diff;
  wire        cal_valid;

  // ********************************************************
  // Pin synchronisers
  // ********************************************************

  // Every pin passes two flops; the edge detector reads the second
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ext_s   <= 2'b00;
      rstn_s  <= 2'b11;
      pdn_s   <= 2'b11;
      start_s <= 2'b00;
      ext_q   <= 1'b0;
    end
    else
    begin
      ext_s   <= {ext_s[0], EXT_CLOCK_INPUT};
      rstn_s  <= {rstn_s[0], RESET_PIN_N};
      pdn_s   <= {pdn_s[0], POWER_DOWN_CTL_N};
      start_s <= {start_s[0], START};
      ext_q   <= ext_s[1];
    end
  end

  assign ext_rise = ext_s[1] & ~ext_q;
  assign soft_rst = CMD_RESET | ~rstn_s[1];
  assign hw_pd    = ~pdn_s[1];
  assign pd       = hw_pd | sw_pdown;
  assign ac_mode  = pol_mode[1];
  assign running  = (state == ST_RUN) && !pd;
  assign conv_done = running && FILTER_VALID;

  // ********************************************************
  // Master clock source
  // ********************************************************

  // External clock counts as present while its edges keep coming
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ext_gap     <= `AMC_EXT_TIMEOUT;
      ext_present <= 1'b0;
    end
    else if (ext_rise)
    begin
      ext_gap     <= 8'h00;
      ext_present <= 1'b1;
    end
    else if (ext_gap != `AMC_EXT_TIMEOUT)
      ext_gap <= ext_gap + 8'h01;
    else
      ext_present <= 1'b0;
  end

  // Internal oscillator as a phase accumulator; jitter of one cycle
  assign nco_sum = {1'b0, nco} + {1'b0, NCO_STEP};

  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      nco         <= 24'h000000;
      MASTER_TICK <= 1'b0;
    end
    else
    begin
      nco         <= nco_sum[23:0];
      MASTER_TICK <= ext_present ? ext_rise : nco_sum[24];
    end
  end

  // ********************************************************
  // Start-up and conversion control
  // ********************************************************

  // Counts are in master clock ticks, not system cycles
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      state          <= ST_POR;
      cnt            <= 17'h00000;
      DATA_READY_OUT <= 1'b0;
    end
    else if (soft_rst)
    begin
      state          <= ST_IDLE;
      cnt            <= 17'h00000;
      DATA_READY_OUT <= (state != ST_POR);
    end
    else if (pd)
    begin
      if (state != ST_POR)
        state <= ST_IDLE;
      cnt <= 17'h00000;
    end
    else
    begin
      case (state)
        ST_POR:
        begin
          if (MASTER_TICK)
          begin
            cnt <= cnt + 17'h00001;
            if (cnt == POR_TICKS[16:0] - 17'h00001)
            begin
              state          <= ST_IDLE;
              DATA_READY_OUT <= 1'b1;
            end
          end
        end
        ST_IDLE:
        begin
          cnt <= 17'h00000;
          if (start_s[1])
            state <= ST_DELAY;
        end
        ST_DELAY:
        begin
          if (!start_s[1])
            state <= ST_IDLE;
          else if (MASTER_TICK)
          begin
            cnt <= cnt + 17'h00001;
            if (cnt == START_TICKS[16:0] - 17'h00001)
              state <= ST_RUN;
          end
        end
        default:
        begin
          if (!start_s[1])
            state <= ST_IDLE;
          if (cal_valid)
            DATA_READY_OUT <= 1'b0;
          else if (DATA_ACK)
            DATA_READY_OUT <= 1'b1;
        end
      endcase
    end
  end

  // Run and power gates to the filter and modulator
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      CONV_RUN    <= 1'b0;
      FUNC_ENABLE <= 1'b0;
      REF_INVERT  <= 1'b0;
    end
    else
    begin
      CONV_RUN    <= running && !soft_rst;
      FUNC_ENABLE <= !pd;
      REF_INVERT  <= running && ac_mode && phase;
    end
  end

  // ********************************************************
  // Alternating polarity combiner
  // ********************************************************

  // First result only primes the pair, which doubles the latency
  assign half_diff = phase ?
    ({prev_data[23], prev_data} - {FILTER_DATA[23], FILTER_DATA}) :
    ({FILTER_DATA[23], FILTER_DATA} - {prev_data[23], prev_data});

  always @(posedge CLK)
  begin
    if (SYS_RST || soft_rst || !running)
    begin
      phase      <= 1'b0;
      have_prev  <= 1'b0;
      prev_data  <= 24'h000000;
      comb_valid <= 1'b0;
      comb_data  <= 24'h000000;
    end
    else if (conv_done && ac_mode)
    begin
      phase      <= ~phase;
      prev_data  <= FILTER_DATA;
      have_prev  <= 1'b1;
      comb_valid <= have_prev;
      comb_data  <= half_diff[24:1];
    end
    else
    begin
      comb_valid <= conv_done;
      comb_data  <= FILTER_DATA;
    end
  end

  // ********************************************************
  // Register file
  // ********************************************************

  // Serial access dies only in pin power-down, not bit power-down
  assign stat_clr = REG_WR && !hw_pd && (REG_ADDR == `AMC_ADDR_STATUS);

  always @(posedge CLK)
  begin
    if (SYS_RST || soft_rst)
    begin
      pol_mode    <= 2'b00;
      sw_pdown    <= 1'b0;
      offset_word <= `AMC_OFS_RESET;
      gain_word   <= `AMC_GAIN_RESET;
    end
    else if (REG_WR && !hw_pd)
    begin
      if (REG_ADDR == `AMC_ADDR_FIRST_MODE_REGISTER)
        pol_mode <= REG_WDATA[`AMC_FIRST_MODE_REGISTER_POL_HI:`AMC_FIRST_MODE_REGISTER_POL_LO];
      else if (REG_ADDR == `AMC_ADDR_THIRD_MODE_REGISTER)
        sw_pdown <= REG_WDATA[`AMC_THIRD_MODE_REGISTER_PDOWN];
      else if (REG_ADDR == `AMC_ADDR_OFS_LO)
        offset_word[7:0] <= REG_WDATA;
      else if (REG_ADDR == `AMC_ADDR_OFS_MID)
        offset_word[15:8] <= REG_WDATA;
      else if (REG_ADDR == `AMC_ADDR_OFS_HI)
        offset_word[23:16] <= REG_WDATA;
      else if (REG_ADDR == `AMC_ADDR_GAIN_LO)
        gain_word[7:0] <= REG_WDATA;
      else if (REG_ADDR == `AMC_ADDR_GAIN_MID)
        gain_word[15:8] <= REG_WDATA;
      else if (REG_ADDR == `AMC_ADDR_GAIN_HI)
        gain_word[23:16] <= REG_WDATA;
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle
  always @(posedge CLK)
  begin
    if (SYS_RST || soft_rst)
    begin
      reset_flag <= 1'b1;
      ovr_flag   <= 1'b0;
    end
    else
    begin
      if (stat_clr && !REG_WDATA[`AMC_STAT_RESET])
        reset_flag <= 1'b0;
      if (DATA_VALID && OVERRANGE)
        ovr_flag <= 1'b1;
      else if (stat_clr && !REG_WDATA[`AMC_STAT_OVR])
        ovr_flag <= 1'b0;
    end
  end

  // Read data is registered; unmapped offsets read zero
  always @(posedge CLK)
  begin
    if (SYS_RST)
      REG_RDATA <= 8'h00;
    else if (REG_RD && !hw_pd)
    begin
      if (REG_ADDR == `AMC_ADDR_STATUS)
        REG_RDATA <= {5'b00000, ovr_flag, ext_present, reset_flag};
      else if (REG_ADDR == `AMC_ADDR_FIRST_MODE_REGISTER)
        REG_RDATA <= {1'b0, pol_mode, 5'b00000};
      else if (REG_ADDR == `AMC_ADDR_THIRD_MODE_REGISTER)
        REG_RDATA <= {sw_pdown, 7'b0000000};
      else if (REG_ADDR == `AMC_ADDR_OFS_LO)
        REG_RDATA <= offset_word[7:0];
      else if (REG_ADDR == `AMC_ADDR_OFS_MID)
        REG_RDATA <= offset_word[15:8];
      else if (REG_ADDR == `AMC_ADDR_OFS_HI)
        REG_RDATA <= offset_word[23:16];
      else if (REG_ADDR == `AMC_ADDR_GAIN_LO)
        REG_RDATA <= gain_word[7:0];
      else if (REG_ADDR == `AMC_ADDR_GAIN_MID)
        REG_RDATA <= gain_word[15:8];
      else if (REG_ADDR == `AMC_ADDR_GAIN_HI)
        REG_RDATA <= gain_word[23:16];
      else
        REG_RDATA <= 8'h00;
    end
  end

  // ********************************************************
  // Calibration and excitation
  // ********************************************************

  amc_cal u_cal
  (
    .clk         (CLK),
    .rst         (SYS_RST),
    .in_valid    (comb_valid),
    .in_data     (comb_data),
    .offset_word (offset_word),
    .gain_word   (gain_word),
    .out_valid   (cal_valid),
    .out_data    (DATA_OUT),
    .out_ovr     (OVERRANGE)
  );

  assign DATA_VALID = cal_valid;

  // Excitation follows the conversion phase only in ac modes
  amc_excite #(.GAP_TICKS(GAP_TICKS)) u_excite
  (
    .clk        (CLK),
    .rst        (SYS_RST),
    .tick       (MASTER_TICK),
    .enable     (running && ac_mode),
    .four_wire  (pol_mode == `AMC_POL_AC4),
    .want_phase (phase),
    .gpio       (EXCITE_GPIO),
    .gpio_oe_n  (EXCITE_GPIO_OE_N)
  );

endmodule // amc_ctl

// >>> design/amc_excite.v
`timescale 1ns/100ps
`include "amc_regs.vh"

// ********************************************************
// Bridge excitation drive with break-before-make gap
// ********************************************************
module amc_excite
#(
  parameter GAP_TICKS = `AMC_GAP_TICKS
)
(
  input  wire       clk,
  input  wire       rst,
  input  wire       tick,
  input  wire       enable,
  input  wire       four_wire,
  input  wire       want_phase,
  output reg  [3:0] gpio,
  output reg        gpio_oe_n
);

  reg        cur_phase;
  reg        drive_a;
  reg        drive_b;
  reg  [7:0] gap;

  // Both phases go off, wait the gap, then the new phase comes on
  always @(posedge clk)
  begin
    if (rst || !enable)
    begin
      cur_phase <= 1'b0;
      drive_a   <= 1'b0;
      drive_b   <= 1'b0;
      gap       <= 8'h00;
    end
    else if (want_phase != cur_phase)
    begin
      drive_a   <= 1'b0;
      drive_b   <= 1'b0;
      cur_phase <= want_phase;
      gap       <= GAP_TICKS[7:0];
    end
    else if (gap != 8'h00)
    begin
      if (tick)
        gap <= gap - 8'h01;
    end
    else
    begin
      drive_a <= ~cur_phase;
      drive_b <= cur_phase;
    end
  end

  // Pin mapping; pins driven low during the gap, output enable off when idle
  always @(posedge clk)
  begin
    if (rst)
    begin
      gpio      <= 4'h0;
      gpio_oe_n <= 1'b1;
    end
    else
    begin
      gpio_oe_n <= ~enable;
      if (four_wire)
        gpio <= {drive_b, drive_a, drive_b, drive_a};
      else
        gpio <= {2'b00, drive_b, drive_a};
    end
  end

endmodule // amc_excite

// >>> design/amc_regs.vh
`ifndef AMC_REGS_VH
`define AMC_REGS_VH

// ********************************************************
// Register offsets
// ********************************************************
`define AMC_ADDR_STATUS   8'h01
`define AMC_ADDR_FIRST_MODE_REGISTER    8'h03
`define AMC_ADDR_THIRD_MODE_REGISTER    8'h05
`define AMC_ADDR_OFS_LO   8'h07
`define AMC_ADDR_OFS_MID  8'h08
`define AMC_ADDR_OFS_HI   8'h09
`define AMC_ADDR_GAIN_LO  8'h0A
`define AMC_ADDR_GAIN_MID 8'h0B
`define AMC_ADDR_GAIN_HI  8'h0C

// ********************************************************
// Field positions and encodings
// ********************************************************
`define AMC_STAT_RESET    0
`define AMC_STAT_CLKEXT   1
`define AMC_STAT_OVR      2
`define AMC_FIRST_MODE_REGISTER_POL_HI  6
`define AMC_FIRST_MODE_REGISTER_POL_LO  5
`define AMC_POL_AC2       2'h2
`define AMC_POL_AC4       2'h3
`define AMC_THIRD_MODE_REGISTER_PDOWN   7

// ********************************************************
// Reset values and calibration arithmetic
// ********************************************************
`define AMC_OFS_RESET     24'h000000
`define AMC_GAIN_RESET    24'h400000
`define AMC_GAIN_SHIFT    22
`define AMC_OVR_LIMIT     28'h087AE13

// ********************************************************
// Timing
// ********************************************************
`define AMC_SYS_HZ        64'd125000000
`define AMC_FCLK_HZ       64'd7372800
`define AMC_NCO_BITS      24
`define AMC_POR_TICKS     65536
`define AMC_START_TICKS   512
`define AMC_GAP_TICKS     8
`define AMC_EXT_TIMEOUT   8'h40

`endif

// >>> test/amc_ctl_monitor.sv
`timescale 1ns/100ps

// ****************************************
// Port checker for the control block
// ****************************************
module amc_ctl_monitor
#(
  parameter POR_TICKS   = 16,
  parameter START_TICKS = 8
)
(
  input wire       CLK,
  input wire       SYS_RST,
  input wire       RESET_PIN_N,
  input wire       POWER_DOWN_CTL_N,
  input wire       START,
  input wire       CMD_RESET,
  input wire       REG_WR,
  input wire       REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  input wire       FILTER_VALID,
  input wire       DATA_VALID,
  input wire       DATA_READY_OUT,
  input wire       CONV_RUN,
  input wire       FUNC_ENABLE,
  input wire       MASTER_TICK,
  input wire [3:0] EXCITE_GPIO
);
  reg [31:0] por_cnt;
  reg [31:0] start_cnt;
  reg        flag_exp;

  // Tick counts as lower bounds, so restarts cannot trip them
  always @(posedge CLK)
  begin
    if (SYS_RST)
      por_cnt <= 32'h0;
    else if (MASTER_TICK)
      por_cnt <= por_cnt + 32'h1;
    if (SYS_RST || !START)
      start_cnt <= 32'h0;
    else if (MASTER_TICK)
      start_cnt <= start_cnt + 32'h1;
  end

  // Expected reset flag; a reset wins over a clear
  always @(posedge CLK)
  begin
    if (SYS_RST || CMD_RESET || !RESET_PIN_N)
      flag_exp <= 1'b1;
    else if (REG_WR && POWER_DOWN_CTL_N && REG_ADDR == 8'h01
             && !REG_WDATA[0])
      flag_exp <= 1'b0;
  end

  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  property p_no_overlap;
    !(EXCITE_GPIO[0] && EXCITE_GPIO[1]);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("excitation phases overlap");
  property p_gap;
    $rose(|EXCITE_GPIO) |-> $past(EXCITE_GPIO, 8) == 4'h0;
  endproperty
  a_gap: assert property (p_gap)
    else $error("no gap before new phase");
  property p_pin_map;
    (EXCITE_GPIO[3:2] & ~EXCITE_GPIO[1:0]) == 2'h0;
  endproperty
  a_pin_map: assert property (p_pin_map)
    else $error("outer pins differ from inner pins");
  property p_cal_lat;
    DATA_VALID |-> $past(FILTER_VALID, 2);
  endproperty
  a_cal_lat: assert property (p_cal_lat)
    else $error("result without conversion");
  property p_por;
    DATA_READY_OUT |-> por_cnt >= POR_TICKS;
  endproperty
  a_por: assert property (p_por)
    else $error("data ready before start-up wait");
  property p_start;
    $rose(CONV_RUN) |-> start_cnt >= START_TICKS;
  endproperty
  a_start: assert property (p_start)
    else $error("conversions began too early");
  property p_hw_pdown;
    (!POWER_DOWN_CTL_N) [*5] |=> !FUNC_ENABLE;
  endproperty
  a_hw_pdown: assert property (p_hw_pdown)
    else $error("functions alive in power-down");
  property p_flag;
    REG_RD && POWER_DOWN_CTL_N && REG_ADDR == 8'h01
      |=> REG_RDATA[0] == flag_exp;
  endproperty
  a_flag: assert property (p_flag)
    else $error("reset flag wrong");
endmodule // amc_ctl_monitor

// >>> test/amc_ctl_tb.sv
`timescale 1ns/100ps
`include "amc_regs.vh"

bind amc_ctl amc_ctl_monitor #(.POR_TICKS(POR_TICKS),
  .START_TICKS(START_TICKS)) amc_ctl_monitor_inst (.CLK(CLK),
  .SYS_RST(SYS_RST), .RESET_PIN_N(RESET_PIN_N), .START(START),
  .POWER_DOWN_CTL_N(POWER_DOWN_CTL_N), .CMD_RESET(CMD_RESET),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CONV_RUN(CONV_RUN),
  .FILTER_VALID(FILTER_VALID), .DATA_VALID(DATA_VALID),
  .DATA_READY_OUT(DATA_READY_OUT), .FUNC_ENABLE(FUNC_ENABLE),
  .MASTER_TICK(MASTER_TICK), .EXCITE_GPIO(EXCITE_GPIO));

module amc_ctl_tb;
  reg         CLK, SYS_RST, EXT_CLOCK_INPUT, POWER_DOWN_CTL_N, START;
  reg         REG_WR, REG_RD, FILTER_VALID, DATA_ACK, ext_on, got_v;
  reg  [7:0]  REG_ADDR, REG_WDATA, d;
  reg  [23:0] FILTER_DATA;
  reg  [24:0] e;
  reg  [3:0]  prev;
  reg  [71:0] cases [0:5];
  wire        RESET_PIN_N, CMD_RESET, DATA_VALID, OVERRANGE, CONV_RUN;
  wire        DATA_READY_OUT, REF_INVERT, FUNC_ENABLE, MASTER_TICK;
  wire        EXCITE_GPIO_OE_N;
  wire [7:0]  REG_RDATA;
  wire [23:0] DATA_OUT;
  wire [3:0]  EXCITE_GPIO;
  integer     fails, checks_done, n, k, j, m;

  amc_ctl #(.POR_TICKS(16), .START_TICKS(8)) amc_ctl_inst (.CLK(CLK),
    .SYS_RST(SYS_RST), .EXT_CLOCK_INPUT(EXT_CLOCK_INPUT),
    .RESET_PIN_N(RESET_PIN_N), .POWER_DOWN_CTL_N(POWER_DOWN_CTL_N),
    .START(START), .CMD_RESET(CMD_RESET), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .FILTER_VALID(FILTER_VALID),
    .FILTER_DATA(FILTER_DATA), .DATA_ACK(DATA_ACK),
    .DATA_VALID(DATA_VALID), .DATA_OUT(DATA_OUT), .OVERRANGE(OVERRANGE),
    .DATA_READY_OUT(DATA_READY_OUT), .CONV_RUN(CONV_RUN),
    .REF_INVERT(REF_INVERT), .FUNC_ENABLE(FUNC_ENABLE),
    .MASTER_TICK(MASTER_TICK), .EXCITE_GPIO(EXCITE_GPIO),
    .EXCITE_GPIO_OE_N(EXCITE_GPIO_OE_N));
  amc_host_model amc_host_model_inst (.clk(CLK),
    .reset_pin_n(RESET_PIN_N), .cmd_reset(CMD_RESET), .cs_n());

  // ****************************************
  // Clocks and shared tasks
  // ****************************************
  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // External master clock, parked low when absent
  always #67.8 EXT_CLOCK_INPUT = ext_on & ~EXT_CLOCK_INPUT;

  task chk(input ok);
  begin
    checks_done = checks_done + 1;
    if (ok !== 1'b1)
    begin
      fails = fails + 1;
      $display("ERROR %0t: mismatch", $time);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] v);
  begin
    @(negedge CLK);
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR = 1'b1;
    @(negedge CLK);
    REG_WR = 1'b0;
  end
  endtask
  // Read data stands one cycle after the strobe
  task rchk(input [7:0] a, input [7:0] msk, input [7:0] v);
  begin
    @(negedge CLK);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLK);
    REG_RD = 1'b0;
    d = REG_RDATA;
    chk((d & msk) === v);
  end
  endtask
  task wr24(input [7:0] a, input [23:0] v);
  begin
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
    wr(a + 8'h02, v[23:16]);
  end
  endtask
  // One conversion; the result is caught within four cycles
  task conv(input [23:0] v);
  begin
    @(negedge CLK);
    FILTER_VALID = 1'b1;
    FILTER_DATA = v;
    got_v = 1'b0;
    for (m = 0; m < 4; m = m + 1)
    begin
      @(negedge CLK);
      FILTER_VALID = 1'b0;
      if (DATA_VALID)
        {got_v, e} = {1'b1, OVERRANGE, DATA_OUT};
    end
    DATA_ACK = 1'b1;
    @(negedge CLK);
    DATA_ACK = 1'b0;
  end
  endtask
  // Master ticks until data ready (sel 0) or running (sel 1)
  task count_ticks(input sel);
  begin
    n = 0;
    for (m = 0; m < 9000 && !(sel ? CONV_RUN : DATA_READY_OUT); m++)
    begin
      @(negedge CLK);
      n = n + MASTER_TICK;
    end
  end
  endtask
  // Expected {overrange, result}: shift is floor division
  function [24:0] cal_exp(input [71:0] c);
    longint p;
    longint lim;
    begin
      lim = longint'(`AMC_OVR_LIMIT);
      p = (longint'($signed(c[71:48])) - longint'($signed(c[47:24])))
          * longint'(c[23:0]);
      p = p >>> `AMC_GAIN_SHIFT;
      cal_exp[24] = p > lim || p < -lim;
      cal_exp[23:0] = p > 8388607 ? 24'h7FFFFF :
                      p < -8388608 ? 24'h800000 : p[23:0];
    end
  endfunction
  task give_verdict;
  begin
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  // Run takes about 3k cycles; cut off well beyond that
  initial
  begin
    #400000;
    fails = fails + 1;
    $display("ERROR %0t: watchdog expired", $time);
    give_verdict;
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    {SYS_RST, POWER_DOWN_CTL_N} = 2'h3;
    {EXT_CLOCK_INPUT, START, REG_WR, REG_RD, FILTER_VALID} = 5'h0;
    {DATA_ACK, ext_on, REG_ADDR, REG_WDATA, FILTER_DATA} = 42'h0;
    {fails, checks_done} = 64'h0;
    cases[0] = {24'h100000, 24'h000010, 24'h400000};
    cases[1] = {24'h200000, 24'h000000, 24'h200000};
    cases[2] = {24'h700000, 24'h000000, 24'h600000};
    cases[3] = {24'h800000, 24'h000001, 24'h400000};
    cases[4] = {24'hFFFFFE, 24'h000000, 24'h433333};
    cases[5] = {24'h7FFFFF, 24'h000000, 24'h420000};
    repeat (4) @(negedge CLK);
    SYS_RST = 1'b0;
    count_ticks(0);
    chk(n >= 16 && n <= 17 && DATA_READY_OUT === 1'b1);
    for (k = 7; k < 13; k = k + 1)
      rchk(k[7:0], 8'hFF, k == 12 ? 8'h40 : 8'h00);
    rchk(8'h20, 8'hFF, 8'h00);
    rchk(8'h01, 8'h01, 8'h01);
    ext_on = 1'b1;
    repeat (60) @(negedge CLK);
    rchk(8'h01, 8'h02, 8'h02);
    ext_on = 1'b0;
    repeat (100) @(negedge CLK);
    rchk(8'h01, 8'h02, 8'h00);
    wr(8'h01, 8'h00);
    rchk(8'h01, 8'h01, 8'h00);
    wr(8'h0C, 8'h20);
    rchk(8'h0C, 8'hFF, 8'h20);
    amc_host_model_inst.cmd_reset_seq;
    rchk(8'h01, 8'h01, 8'h01);
    rchk(8'h0C, 8'hFF, 8'h40);
    wr(8'h01, 8'h00);
    wr(8'h0B, 8'h33);
    amc_host_model_inst.pin_reset;
    repeat (4) @(negedge CLK);
    rchk(8'h01, 8'h01, 8'h01);
    rchk(8'h0B, 8'hFF, 8'h00);
    START = 1'b1;
    count_ticks(1);
    chk(n >= 8 && n <= 9 && CONV_RUN === 1'b1);
    for (k = 0; k < 6; k = k + 1)
    begin
      wr24(8'h07, cases[k][47:24]);
      wr24(8'h0A, cases[k][23:0]);
      rchk(8'h09, 8'hFF, cases[k][47:40]);
      conv(cases[k][71:48]);
      chk(got_v === 1'b1 && e === cal_exp(cases[k]));
    end
    // Alternating modes: feed +A or -A plus a fixed input offset
    for (k = 0; k < 2; k = k + 1)
    begin
      wr24(8'h07, 24'h000000);
      wr24(8'h0A, 24'h400000);
      wr(8'h03, k ? 8'h60 : 8'h40);
      START = 1'b0;
      repeat (4) @(negedge CLK);
      START = 1'b1;
      count_ticks(1);
      for (j = 0; j < 4; j = j + 1)
      begin
        conv(REF_INVERT ? 24'h000100 - 24'h012340 : 24'h012440);
        chk(got_v === (j > 0));
        if (j > 0)
          chk(e[23:0] === 24'h012340);
        repeat (200) @(negedge CLK);
        chk((EXCITE_GPIO[0] ^ EXCITE_GPIO[1]) === 1'b1);
        chk(EXCITE_GPIO[3:2] === (k ? EXCITE_GPIO[1:0] : 2'h0));
        chk(EXCITE_GPIO_OE_N === 1'b0);
        if (j > 0)
          chk(EXCITE_GPIO !== prev);
        prev = EXCITE_GPIO;
      end
    end
    // Hardware power-down refuses access; data kept on wake-up
    POWER_DOWN_CTL_N = 1'b0;
    repeat (6) @(negedge CLK);
    chk(FUNC_ENABLE === 1'b0);
    wr(8'h0C, 8'h11);
    rchk(8'h0C, 8'hFF, 8'h00);
    POWER_DOWN_CTL_N = 1'b1;
    repeat (6) @(negedge CLK);
    chk(FUNC_ENABLE === 1'b1);
    rchk(8'h0C, 8'hFF, 8'h40);
    wr(8'h05, 8'h80);
    repeat (3) @(negedge CLK);
    chk(FUNC_ENABLE === 1'b0);
    rchk(8'h0C, 8'hFF, 8'h40);
    wr(8'h05, 8'h00);
    repeat (3) @(negedge CLK);
    chk(FUNC_ENABLE === 1'b1);
    give_verdict;
  end
endmodule // amc_ctl_tb

// >>> test/amc_host_model.sv
`timescale 1ns/100ps

// ****************************************
// Host side of the reset pin and command
// ****************************************
module amc_host_model
(
  input  wire clk,
  output reg  reset_pin_n,
  output reg  cmd_reset,
  output reg  cs_n
);
  // Idle levels
  initial
  begin
    reset_pin_n = 1'b1;
    cmd_reset   = 1'b0;
    cs_n        = 1'b0;
  end

  // Pin reset: low a few cycles, then high again
  task pin_reset;
  begin
    @(negedge clk);
    reset_pin_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_pin_n = 1'b1;
  end
  endtask

  // Select pulsed high first so the serial side starts clean
  task cmd_reset_seq;
  begin
    @(negedge clk);
    cs_n = 1'b1;
    repeat (2) @(negedge clk);
    cs_n = 1'b0;
    @(negedge clk);
    cmd_reset = 1'b1;
    @(negedge clk);
    cmd_reset = 1'b0;
  end
  endtask
endmodule // amc_host_model
